// File: gpm_defines.vh
/*
 * Constants for the graphics power management capability block:
 * configuration offsets, fixed field values, reset values and the
 * power state encodings.
 * Assumes configuration offsets are byte addresses of an 8-bit space.
 */
`ifndef GPM_DEFINES_VH
`define GPM_DEFINES_VH

// Header locations (byte offsets; the status word sits at 06h inside dword 04h)
`define GPM_OFF_CMD_STATUS   8'h04
`define GPM_OFF_STATUS       8'h06
`define GPM_OFF_FIRST_CAP    8'h34

// Capabilities flag: bit 4 of the status word, which sits in lanes 3:2
`define GPM_STATUS_CAPS_BIT  4
`define GPM_STATUS_LANE_BIT  16

// First-capability offset default, low two bits forced to zero
`define GPM_FIRST_CAP_RST    8'h50
`define GPM_CAP_ALIGN_MASK   8'hFC

// Offsets inside the capability item
`define GPM_ITEM_TYPE        8'h00
`define GPM_ITEM_NEXT        8'h01
`define GPM_ITEM_CAPS        8'h02
`define GPM_ITEM_CTRL        8'h04
`define GPM_ITEM_RSVD        8'h06

// Fixed read-only contents of the capability item
`define GPM_TYPE_CODE        8'h01
`define GPM_NEXT_OFFSET      8'h80
`define GPM_CAPS_WORD        16'h3E21

// Control/status word layout and reset value
`define GPM_PS_MSB           1
`define GPM_PS_LSB           0
`define GPM_PS_RST           2'h0
`define GPM_CLK_MSB          15
`define GPM_CLK_LSB          2
`define GPM_CLK_W            14

// Power state encodings
`define GPM_PS_D0            2'h0
`define GPM_PS_D1            2'h1
`define GPM_PS_D2            2'h2
`define GPM_PS_D3            2'h3

// Decoded register classes
`define GPM_DEC_NONE         3'h0
`define GPM_DEC_STATUS       3'h1
`define GPM_DEC_FIRST_CAP    3'h2
`define GPM_DEC_ITEM_ID      3'h3
`define GPM_DEC_ITEM_CTRL    3'h4

`endif

// File: gpm_sync.v
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes inputs are asynchronous to clk_i; an output bit follows
 * once the second and third stages agree.
 */
`timescale 1ns/10ps
module gpm_sync
#(
	parameter WIDTH = 1
)
(
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire [WIDTH-1:0] async_i,
	output reg  [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] stage1_r;
	reg [WIDTH-1:0] stage2_r;
	reg [WIDTH-1:0] stage3_r;

	genvar g;

	// First stage feeds only the second stage to keep metastability contained
	generate
		for (g = 0; g < WIDTH; g = g + 1)
		begin : g_bit
			always @(posedge clk_i)
			begin
				if (rst_i)
				begin
					stage1_r[g] <= 1'b0;
					stage2_r[g] <= 1'b0;
					stage3_r[g] <= 1'b0;
					sync_o[g]   <= 1'b0;
				end
				else
				begin
					stage1_r[g] <= async_i[g];
					stage2_r[g] <= stage1_r[g];
					stage3_r[g] <= stage2_r[g];
					if (stage2_r[g] == stage3_r[g])
						sync_o[g] <= stage3_r[g];
				end
			end
		end
	endgenerate

endmodule

// File: gpm_caps.v
/*
 * Configuration register logic for the graphics power management
 * capability: status capabilities flag, first-capability offset,
 * the capability item and the power state controls it drives.
 * Assumes a single-clock configuration port from the host interface
 * unit, one request at a time, each request a one-cycle pulse.
 * Clock tree status and the link stop pin come from other domains
 * and are synchronised here; the stop permit source is on this clock.
 */
// What this block does
// - Status capabilities bit reads one, low bits zero
// - First-capability offset reads 50h, dword aligned
// - Power capability is first, type code 01h
// - Item layout: type, next, caps, control, reserved
// - Byte, word and dword accesses all accepted
// - Reserved writes complete, data discarded
// - Reserved or unmapped reads complete with zero
// - Power state field resets to D0
// - D1 turns display off, keeps DRAM access
// - D2 stops display, engines, frame buffer access
// - D3 leaves only the host interface alive
// - Control bits 15:2 report clock tree status
// - Item offsets decoded from its base pointer
// - D1 keeps configuration, state and memory
// - D3 hot also shuts graphics PLLs
// - Link stop only while permit is driven
// - Next offset reads 80h
// - Capabilities word fixed: PME, D1, D2, init, version
`timescale 1ns/10ps
`include "gpm_defines.vh"

module gpm_caps
(
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        cfg_req_i,
	input  wire        cfg_we_i,
	input  wire [7:0]  cfg_addr_i,
	input  wire [3:0]  cfg_be_i,
	input  wire [31:0] cfg_wdata_i,
	output reg         cfg_ack_o,
	output reg  [31:0] cfg_rdata_o,
	input  wire [13:0] clk_tree_run_i,
	input  wire        sys_stop_ok_i,
	input  wire        link_stop_n_i,
	output reg  [1:0]  power_state_o,
	output reg         display_en_o,
	output reg         engine_en_o,
	output reg         fb_host_en_o,
	output reg         dram_host_en_o,
	output reg         gfx_pll_en_o,
	output reg         core_pwr_en_o,
	output reg         link_stop_permit_o,
	output reg         link_stop_err_o
);

	// Enable vector bit positions
	localparam EN_DISP = 0;
	localparam EN_ENG  = 1;
	localparam EN_FB   = 2;
	localparam EN_DRAM = 3;
	localparam EN_PLL  = 4;
	localparam EN_CORE = 5;

	// Capability base; read-only so it stays at its aligned default
	wire [7:0]  cap_base;
	// Synchronised clock tree status and link stop activity
	wire [14:0] sync_out;
	wire [13:0] clk_status;
	wire        link_stop_act;

	reg  [1:0]  power_state_r;
	reg  [1:0]  power_state_nxt;
	reg  [2:0]  rd_class;
	reg  [2:0]  wr_class;
	reg  [31:0] rd_word;
	reg  [31:0] rd_masked;
	reg  [5:0]  enables;

	// Masking keeps the base dword aligned even if the default were edited
	assign cap_base = `GPM_FIRST_CAP_RST & `GPM_CAP_ALIGN_MASK;

	// Address decode shared by the read and write paths; the item is
	// located relative to its base so moving the pointer moves the item
	function [2:0] gpm_decode;
		input [7:0] addr;
		input [7:0] base;
		reg   [7:0] dw;
		reg   [7:0] rel;
		begin
			dw  = addr & `GPM_CAP_ALIGN_MASK;
			rel = dw - base;
			// Header dwords are matched first, so the item can never shadow them
			if (dw == `GPM_OFF_CMD_STATUS)
				gpm_decode = `GPM_DEC_STATUS;
			else if (dw == `GPM_OFF_FIRST_CAP)
				gpm_decode = `GPM_DEC_FIRST_CAP;
			else if (rel == `GPM_ITEM_TYPE)
				gpm_decode = `GPM_DEC_ITEM_ID;
			else if (rel == `GPM_ITEM_CTRL)
				gpm_decode = `GPM_DEC_ITEM_CTRL;
			else
				gpm_decode = `GPM_DEC_NONE;
		end
	endfunction

	// Per-state enables: display, engines, frame buffer, DRAM, PLL, core
	function [5:0] gpm_enables;
		input [1:0] st;
		begin
			case (st)
				`GPM_PS_D0:
					gpm_enables = 6'h3F;
				`GPM_PS_D1:
					gpm_enables = 6'h3E;
				`GPM_PS_D2:
					gpm_enables = 6'h38;
				`GPM_PS_D3:
					gpm_enables = 6'h00;
				default:
					gpm_enables = 6'h3F;
			endcase
		end
	endfunction

	// Clock trees and the link stop pin come from other domains
	gpm_sync
	#(
		.WIDTH (15)
	)
	u_sync
	(
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({~link_stop_n_i, clk_tree_run_i}),
		.sync_o  (sync_out)
	);

	assign clk_status    = sync_out[13:0];
	assign link_stop_act = sync_out[14];

	// Read data assembly for the addressed dword
	always @*
	begin
		rd_class = gpm_decode(cfg_addr_i, cap_base);
		rd_word  = 32'h0000_0000;
		case (rd_class)
			`GPM_DEC_STATUS:
			begin
				// Only the capabilities flag lives here; other status bits and
				// the command word belong to the rest of the header
				rd_word[`GPM_STATUS_LANE_BIT + `GPM_STATUS_CAPS_BIT] = 1'b1;
			end
			`GPM_DEC_FIRST_CAP:
			begin
				rd_word[7:0] = cap_base;
			end
			`GPM_DEC_ITEM_ID:
			begin
				rd_word[7:0]   = `GPM_TYPE_CODE;
				rd_word[15:8]  = `GPM_NEXT_OFFSET;
				rd_word[31:16] = `GPM_CAPS_WORD;
			end
			`GPM_DEC_ITEM_CTRL:
			begin
				rd_word[`GPM_PS_MSB:`GPM_PS_LSB]   = power_state_r;
				rd_word[`GPM_CLK_MSB:`GPM_CLK_LSB] = clk_status;
				// Reserved word at item offset 06h stays zero
				rd_word[31:16] = 16'h0000;
			end
			default:
			begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	// Lanes outside the byte enables read zero, so any width works
	always @*
	begin
		rd_masked = rd_word & {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}},
			{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
	end

	// Write path: only the power state field is writable
	always @*
	begin
		wr_class        = gpm_decode(cfg_addr_i, cap_base);
		power_state_nxt = power_state_r;
		if (cfg_req_i && cfg_we_i && (wr_class == `GPM_DEC_ITEM_CTRL) && cfg_be_i[0])
			power_state_nxt = cfg_wdata_i[`GPM_PS_MSB:`GPM_PS_LSB];
		// Writes to any other dword, or to read-only bits, are dropped
		// while still acknowledged below
	end

	// Power state register
	always @(posedge clk_i)
	begin
		if (rst_i)
			power_state_r <= `GPM_PS_RST;
		else
			power_state_r <= power_state_nxt;
	end

	// Acknowledge every access, mapped or not, one cycle after the request
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cfg_ack_o   <= 1'b0;
			cfg_rdata_o <= 32'h0000_0000;
		end
		else
		begin
			cfg_ack_o <= cfg_req_i;
			if (cfg_req_i && !cfg_we_i)
				cfg_rdata_o <= rd_masked;
			else
				cfg_rdata_o <= 32'h0000_0000;
		end
	end

	// Enables follow the stored state, so they change in the same cycle as the
	// write is acknowledged and never mid-access; the registered outputs follow one cycle later
	always @*
	begin
		enables = gpm_enables(power_state_r);
	end

	// Registered power controls; host interface logic is never gated here
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			power_state_o  <= `GPM_PS_RST;
			display_en_o   <= 1'b1;
			engine_en_o    <= 1'b1;
			fb_host_en_o   <= 1'b1;
			dram_host_en_o <= 1'b1;
			gfx_pll_en_o   <= 1'b1;
			core_pwr_en_o  <= 1'b1;
		end
		else
		begin
			power_state_o  <= power_state_r;
			display_en_o   <= enables[EN_DISP];
			engine_en_o    <= enables[EN_ENG];
			fb_host_en_o   <= enables[EN_FB];
			dram_host_en_o <= enables[EN_DRAM];
			gfx_pll_en_o   <= enables[EN_PLL];
			core_pwr_en_o  <= enables[EN_CORE];
		end
	end

	// Link stop permit comes from system power logic on this clock; a
	// stop seen without permit is latched until reset for diagnosis
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			link_stop_permit_o <= 1'b0;
			link_stop_err_o    <= 1'b0;
		end
		else
		begin
			link_stop_permit_o <= sys_stop_ok_i;
			if (link_stop_act && !link_stop_permit_o)
				link_stop_err_o <= 1'b1;
		end
	end

endmodule

// File: gpm_caps_sva.sv
/* Checker for gpm_caps: config answers, fixed map, state outputs.
   Assumes it sees only the ports of gpm_caps, bound below. */
`timescale 1ns/10ps
module gpm_caps_sva
(
	input wire        clk_i,
	input wire        rst_i,
	input wire        cfg_req_i,
	input wire        cfg_we_i,
	input wire [7:0]  cfg_addr_i,
	input wire [3:0]  cfg_be_i,
	input wire [31:0] cfg_wdata_i,
	input wire        cfg_ack_o,
	input wire [31:0] cfg_rdata_o,
	input wire [13:0] clk_tree_run_i,
	input wire        sys_stop_ok_i,
	input wire        link_stop_n_i,
	input wire [1:0]  power_state_o,
	input wire        display_en_o,
	input wire        engine_en_o,
	input wire        fb_host_en_o,
	input wire        dram_host_en_o,
	input wire        gfx_pll_en_o,
	input wire        core_pwr_en_o,
	input wire        link_stop_permit_o,
	input wire        link_stop_err_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Full-dword reads only, so every lane is compared
	wire       rd = cfg_req_i && !cfg_we_i && cfg_be_i == 4'hF;
	wire [5:0] dw = cfg_addr_i[7:2];
	a_ack_next: assert property (cfg_req_i |=> cfg_ack_o)
		else $error("no ack after request");
	a_ack_only: assert property (!cfg_req_i |=> !cfg_ack_o)
		else $error("ack without request");
	a_item_read: assert property (rd && dw == 6'h14 |=> cfg_rdata_o == 32'h3E218001)
		else $error("item dword wrong");
	a_ptr_read: assert property (rd && dw == 6'h0D |=> cfg_rdata_o == 32'h00000050)
		else $error("first offset wrong");
	a_status_read: assert property (rd && dw == 6'h01 |=> cfg_rdata_o == 32'h00100000)
		else $error("status word wrong");
	a_unmapped_zero: assert property (rd && !(dw inside {1, 13, 20, 21})
		|=> cfg_rdata_o == 0)
		else $error("unmapped read not zero");
	a_d1_outputs: assert property (power_state_o == 2'h1
		|-> !display_en_o && dram_host_en_o)
		else $error("D1 outputs wrong");
	a_d2_outputs: assert property (power_state_o == 2'h2
		|-> !(display_en_o | engine_en_o | fb_host_en_o))
		else $error("D2 outputs wrong");
	a_d3_outputs: assert property (power_state_o == 2'h3
		|-> !(gfx_pll_en_o | core_pwr_en_o))
		else $error("D3 outputs wrong");
	a_state_write: assert property (cfg_req_i && cfg_we_i && dw == 6'h15 && cfg_be_i[0]
		|=> ##1 power_state_o == $past(cfg_wdata_i[1:0], 2))
		else $error("state write not applied");
	a_permit_follow: assert property (!$past(rst_i)
		|-> link_stop_permit_o == $past(sys_stop_ok_i))
		else $error("permit does not follow");
	c_write: cover property (cfg_req_i && cfg_we_i);
	c_d3: cover property (power_state_o == 2'h3);
	c_err: cover property (link_stop_err_o);
endmodule
bind gpm_caps gpm_caps_sva gpm_caps_sva_i (.*);

// File: tb_gpm_caps.sv
/* Testbench for gpm_caps: register map, power states, clock status, link stop.
   Assumes gpm_caps_sva is compiled and bound alongside. */
`timescale 1ns/10ps
module tb_gpm_caps;
	reg         clk_i = 0, rst_i = 1, req = 0, we = 0, stop_ok = 0, stop_n = 1;
	reg  [7:0]  addr = 8'h00;
	reg  [3:0]  be = 4'h0;
	reg  [31:0] wd = 32'h00000000, got;
	reg  [13:0] tree = 14'h0000;
	wire        ack, permit, err;
	wire [31:0] rd;
	wire [1:0]  ps;
	wire [5:0]  en;
	integer     fail_count = 0, n_compared = 0, i;
	gpm_caps gpm_caps_i (.clk_i(clk_i), .rst_i(rst_i), .cfg_req_i(req), .cfg_we_i(we),
		.cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_ack_o(ack),
		.cfg_rdata_o(rd), .clk_tree_run_i(tree), .sys_stop_ok_i(stop_ok),
		.link_stop_n_i(stop_n), .power_state_o(ps), .display_en_o(en[5]),
		.engine_en_o(en[4]), .fb_host_en_o(en[3]), .dram_host_en_o(en[2]),
		.gfx_pll_en_o(en[1]), .core_pwr_en_o(en[0]), .link_stop_permit_o(permit),
		.link_stop_err_o(err));
	initial forever #12.5 clk_i = ~clk_i;
	task chk(input [31:0] seen, input [31:0] exp);
	begin
		n_compared = n_compared + 1;
		if (seen !== exp)
		begin
			fail_count = fail_count + 1;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	// One access; ack and read data stand only in the cycle after the request edge
	task acc(input w, input [7:0] a, input [3:0] b, input [31:0] d);
	begin
		@(negedge clk_i);
		req = 1; we = w; addr = a; be = b; wd = d;
		@(negedge clk_i);
		chk(ack, 1);
		got = rd;
		req = 0;
	end
	endtask
	task rdchk(input [7:0] a, input [3:0] b, input [31:0] e);
	begin
		acc(0, a, b, 0);
		chk(got, e);
	end
	endtask
	task t_map;
	begin
		rdchk(8'h07, 4'h4, 32'h00100000);
		rdchk(8'h04, 4'hF, 32'h00100000);
		rdchk(8'h34, 4'hF, 32'h00000050);
		rdchk(8'h50, 4'h1, 32'h00000001);
		rdchk(8'h51, 4'h2, 32'h00008000);
		rdchk(8'h52, 4'hC, 32'h3E210000);
		rdchk(8'h50, 4'hF, 32'h3E218001);
		rdchk(8'h54, 4'hF, 32'h00000000);
		rdchk(8'h56, 4'hC, 32'h00000000);
		rdchk(8'h58, 4'hF, 32'h00000000);
		$display("test map done");
	end
	endtask
	// Upper lane-0 bits are written as ones; only the field may take them
	task t_states;
		reg [1:0] s;
		reg [5:0] m, x;
	begin
		for (i = 1; i < 5; i = i + 1)
		begin
			s = i[1:0];
			acc(1, 8'h54, 4'h1, {30'h3FFFFFFF, s});
			rdchk(8'h54, 4'h1, {30'h0, s});
			chk(ps, s);
			m = (s == 2'h2) ? 6'h3B : 6'h3F;
			x = (s == 2'h0) ? 6'h3F : (s == 2'h1) ? 6'h1F : (s == 2'h2) ? 6'h03 : 6'h00;
			chk(en & m, x);
		end
		$display("test states done");
	end
	endtask
	task t_rsvd;
	begin
		acc(1, 8'h54, 4'h1, 32'h00000001);
		acc(1, 8'h54, 4'hE, 32'hFFFFFFFF);
		acc(1, 8'h50, 4'hF, 32'h00000000);
		acc(1, 8'h34, 4'hF, 32'h00000000);
		acc(1, 8'h60, 4'hF, 32'hFFFFFFFF);
		rdchk(8'h54, 4'hF, 32'h00000001);
		rdchk(8'h50, 4'hF, 32'h3E218001);
		rdchk(8'h34, 4'hF, 32'h00000050);
		rdchk(8'h60, 4'hF, 32'h00000000);
		chk(en, 6'h1F);
		acc(1, 8'h54, 4'h1, 32'h00000000);
		$display("test reserved done");
	end
	endtask
	// Status passes a synchroniser, so allow it several cycles
	task t_clk;
	begin
		tree = 14'h2A5B;
		repeat (8) @(negedge clk_i);
		rdchk(8'h54, 4'h3, {16'h0, 14'h2A5B, 2'h0});
		tree = 14'h15A4;
		repeat (8) @(negedge clk_i);
		rdchk(8'h54, 4'h2, 32'h00005600);
		$display("test clock status done");
	end
	endtask
	task t_link;
	begin
		stop_ok = 1;
		repeat (2) @(negedge clk_i);
		chk(permit, 1);
		stop_n = 0;
		repeat (8) @(negedge clk_i);
		chk(err, 0);
		stop_ok = 0;
		repeat (8) @(negedge clk_i);
		chk(permit, 0);
		chk(err, 1);
		stop_n = 1;
		// Mid-run reset from D3 with the error flag set
		acc(1, 8'h54, 4'h1, 32'h00000003);
		@(negedge clk_i);
		chk(ps, 2'h3);
		rst_i = 1;
		repeat (2) @(negedge clk_i);
		chk({ps, en, permit, err}, 10'h0FC);
		rst_i = 0;
		$display("test link stop done");
	end
	endtask
	task report_and_stop;
	begin
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	// Whole run is about a hundred cycles; this is far beyond it
	initial
	begin
		#(4000 * 25);
		fail_count = fail_count + 1;
		report_and_stop;
	end
	initial
	begin
		repeat (3) @(negedge clk_i);
		chk({ps, en, permit, err}, 10'h0FC);
		rst_i = 0;
		t_map;
		t_states;
		t_rsvd;
		t_clk;
		t_link;
		report_and_stop;
	end
endmodule
